// >>> design/tcc_timer16.sv
// 16-bit up/down timer with input capture and an 8-bit register port.
// Assumes a processor issuing single-cycle read/write strobes and all
// pins synchronous to core_clk.
//
// Functional notes
// - Count reads low first, latch catches high
// - Low count write commits latch plus byte
// - Latch holds value across several low writes
// - Clock select picks tick; zero stops
// - Each tick clears, increments or decrements count
// - Count accessible whether ticking or not
// - Processor count write beats counting
// - Mode field split across both control registers
// - Overflow flag set where mode defines
// - Top, bottom indications; clear zeroes count
// - Qualified edge copies count into capture
// - Capture flag set with capture copy
// - Capture flag interrupts; cleared by ack/one
// - Capture low read loads latch high
// - Capture writable only in capture-top modes
// - One latch shared by all 16-bit registers
// - Low write moves latch and byte together
`include "tcc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tcc_timer16
   import tcc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [3:0] busAddr,
   input wire logic busWr,
   input wire logic busRd,
   input wire logic [7:0] busWrData,
   input wire logic ovfIrqAck,
   input wire logic capIrqAck,
   input wire logic capturePin,
   input wire logic comparatorOut,
   input wire logic extClkPin,
   output logic [7:0] busRdData,
   output logic ovfIrq,
   output logic capIrq
);

   // ==========================================================
   // State
   logic [15:0] timerCount;
   logic [15:0] captureValue;
   logic [15:0] compareA, compareB;
   logic [7:0] tempLatch;
   logic [7:0] controlRegA;
   logic [7:0] controlRegB;
   logic [7:0] timerFlagReg;
   logic [7:0] timerIrqMaskReg;
   logic [`TCC_PRE_W-1:0] prescale;
   logic extPrev, capPrev;
   tcc_dir_type dir;

   // ==========================================================
   // Address decode
   wire wrCountLo = busWr && busAddr == `TCC_ADDR_COUNT_LO;
   wire wrCaptLo = busWr && busAddr == `TCC_ADDR_CAPT_LO;
   wire wrCmpALo = busWr && busAddr == `TCC_ADDR_CMPA_LO;
   wire wrCmpBLo = busWr && busAddr == `TCC_ADDR_CMPB_LO;
   wire wrAnyHi = busWr && (busAddr == `TCC_ADDR_COUNT_HI
      || busAddr == `TCC_ADDR_CAPT_HI || busAddr == `TCC_ADDR_CMPA_HI
      || busAddr == `TCC_ADDR_CMPB_HI);
   wire wrFlag = busWr && busAddr == `TCC_ADDR_FLAG;
   wire rdCountLo = busRd && busAddr == `TCC_ADDR_COUNT_LO;
   wire rdCaptLo = busRd && busAddr == `TCC_ADDR_CAPT_LO;

   // ==========================================================
   // Mode decode
   wire [3:0] waveformMode = {controlRegB[`TCC_CTRLB_WGM_HI],
      controlRegA[`TCC_CTRLA_WGM_LO]};
   wire [2:0] clockSel = controlRegB[`TCC_CTRLB_CS];

   // Modes whose top comes from the capture register
   function automatic logic topIsCapture(input logic [3:0] m);
      return m == 4'h8 || m == 4'hA || m == 4'hC || m == 4'hE;
   endfunction

   wire captTop = topIsCapture(waveformMode);
   wire dualSlope = waveformMode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
      4'hA, 4'hB};
   wire clearMode = waveformMode == 4'h4 || waveformMode == 4'hC;
   wire fastMode = waveformMode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};

   // Top of the sequence for the current mode
   logic [15:0] topValue;
   always_comb begin
      unique case (waveformMode)
         4'h1, 4'h5: topValue = `TCC_TOP8;
         4'h2, 4'h6: topValue = `TCC_TOP9;
         4'h3, 4'h7: topValue = `TCC_TOP10;
         4'h4, 4'h9, 4'hB, 4'hF: topValue = compareA;
         4'h8, 4'hA, 4'hC, 4'hE: topValue = captureValue;
         default: topValue = `TCC_MAX;
      endcase
   end

   // Top and bottom indications
   wire atTop = timerCount == topValue;
   wire atBottom = timerCount == `TCC_RST_WORD;
   wire atMax = timerCount == `TCC_MAX;

   // ==========================================================
   // Tick selection; a stopped timer simply sees no tick
   wire extFall = extPrev && !extClkPin;
   wire extRise = !extPrev && extClkPin;
   logic timerTick;
   always_comb begin
      unique case (clockSel)
         `TCC_CS_STOP: timerTick = 1'b0;
         `TCC_CS_DIV1: timerTick = 1'b1;
         `TCC_CS_DIV8: timerTick = &prescale[2:0];
         `TCC_CS_DIV64: timerTick = &prescale[5:0];
         `TCC_CS_DIV256: timerTick = &prescale[7:0];
         `TCC_CS_DIV1024: timerTick = &prescale[9:0];
         `TCC_CS_EXT_FALL: timerTick = extFall;
         default: timerTick = extRise;
      endcase
   end

   // ==========================================================
   // Next count: the processor write wins over any tick
   logic [15:0] next_timerCount;
   tcc_dir_type next_dir;
   logic ovfEvent;
   always_comb begin
      next_timerCount = timerCount;
      next_dir = dir;
      ovfEvent = 1'b0;
      if (wrCountLo) begin
         next_timerCount = {tempLatch, busWrData};
      end else if (timerTick) begin
         if (dualSlope) begin
            // Turn at either end first, then step the new way
            if (dir == TCC_UP && atTop) begin
               next_dir = TCC_DOWN;
            end else if (dir == TCC_DOWN && atBottom) begin
               next_dir = TCC_UP;
               ovfEvent = 1'b1;
            end
            next_timerCount = (next_dir == TCC_UP) ? timerCount + 16'h0001
               : timerCount - 16'h0001;
         end else if ((clearMode || fastMode) && atTop) begin
            next_timerCount = `TCC_RST_WORD;
            ovfEvent = fastMode || atMax;
         end else begin
            next_timerCount = timerCount + 16'h0001;
            ovfEvent = atMax;
         end
      end
   end

   // ==========================================================
   // Capture source, edge and enable; capture-top modes block it
   wire capSrc = controlRegB[`TCC_CTRLB_SRC] ? comparatorOut : capturePin;
   wire capEdge = controlRegB[`TCC_CTRLB_EDGE] ? (!capPrev && capSrc)
      : (capPrev && !capSrc);
   wire capEvent = capEdge && !captTop;

   // ==========================================================
   // Read mux; the output flop holds zero outside a read
   logic [7:0] next_busRdData;
   always_comb begin
      unique case (busAddr)
         `TCC_ADDR_COUNT_LO: next_busRdData = timerCount[7:0];
         `TCC_ADDR_CAPT_LO: next_busRdData = captureValue[7:0];
         `TCC_ADDR_CMPA_LO: next_busRdData = compareA[7:0];
         `TCC_ADDR_CMPA_HI: next_busRdData = compareA[15:8];
         `TCC_ADDR_CMPB_LO: next_busRdData = compareB[7:0];
         `TCC_ADDR_CMPB_HI: next_busRdData = compareB[15:8];
         `TCC_ADDR_COUNT_HI, `TCC_ADDR_CAPT_HI:
            next_busRdData = tempLatch;
         `TCC_ADDR_CTRL_A: next_busRdData = controlRegA;
         `TCC_ADDR_CTRL_B: next_busRdData = controlRegB;
         `TCC_ADDR_FLAG: next_busRdData = timerFlagReg;
         `TCC_ADDR_MASK: next_busRdData = timerIrqMaskReg;
         default: next_busRdData = `TCC_RST_BYTE;
      endcase
   end

   // Shared high-byte latch; only high writes and low reads touch it
   wire [7:0] next_tempLatch = wrAnyHi ? busWrData
      : rdCountLo ? timerCount[15:8]
      : rdCaptLo ? captureValue[15:8] : tempLatch;

   // Flags: hardware set beats clear by write-one or acknowledge
   wire ovfClr = (wrFlag && busWrData[`TCC_FLAG_OVF]) || ovfIrqAck;
   wire capClr = (wrFlag && busWrData[`TCC_FLAG_CAPT]) || capIrqAck;
   wire next_ovfFlag = ovfEvent || (timerFlagReg[`TCC_FLAG_OVF] && !ovfClr);
   wire next_capFlag = capEvent
      || (timerFlagReg[`TCC_FLAG_CAPT] && !capClr);

   // ==========================================================
   // Counter, direction, prescaler and edge history
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         timerCount <= `TCC_RST_WORD;
         dir <= TCC_UP;
         prescale <= '0;
         extPrev <= 1'b0;
         capPrev <= 1'b0;
      end else begin
         timerCount <= next_timerCount;
         dir <= next_dir;
         prescale <= prescale + 1'b1;
         extPrev <= extClkPin;
         capPrev <= capSrc;
      end
   end

   // Capture register: edge copies count, write only in capture-top modes
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         captureValue <= `TCC_RST_WORD;
      end else if (capEvent) begin
         captureValue <= timerCount;
      end else if (wrCaptLo && captTop) begin
         captureValue <= {tempLatch, busWrData};
      end
   end

   // Compare values, latch, control and flag registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         compareA <= `TCC_RST_WORD;
         compareB <= `TCC_RST_WORD;
         tempLatch <= `TCC_RST_BYTE;
         controlRegA <= `TCC_RST_BYTE;
         controlRegB <= `TCC_RST_BYTE;
         timerIrqMaskReg <= `TCC_RST_BYTE;
         timerFlagReg <= `TCC_RST_BYTE;
      end else begin
         if (wrCmpALo) compareA <= {tempLatch, busWrData};
         if (wrCmpBLo) compareB <= {tempLatch, busWrData};
         tempLatch <= next_tempLatch;
         if (busWr && busAddr == `TCC_ADDR_CTRL_A) controlRegA <= busWrData;
         if (busWr && busAddr == `TCC_ADDR_CTRL_B) controlRegB <= busWrData;
         if (busWr && busAddr == `TCC_ADDR_MASK) timerIrqMaskReg <= busWrData;
         timerFlagReg[`TCC_FLAG_OVF] <= next_ovfFlag;
         timerFlagReg[`TCC_FLAG_CAPT] <= next_capFlag;
      end
   end

   // Registered outputs; interrupt follows flag and mask by one cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         busRdData <= `TCC_RST_BYTE;
         ovfIrq <= 1'b0;
         capIrq <= 1'b0;
      end else begin
         busRdData <= busRd ? next_busRdData : `TCC_RST_BYTE;
         ovfIrq <= timerFlagReg[`TCC_FLAG_OVF]
            && timerIrqMaskReg[`TCC_FLAG_OVF];
         capIrq <= timerFlagReg[`TCC_FLAG_CAPT]
            && timerIrqMaskReg[`TCC_FLAG_CAPT];
      end
   end

   // ==========================================================
   // Assertions
   property p_rd_lo_latch;
      @(posedge core_clk) disable iff (!rst_b)
      rdCountLo && !wrAnyHi |=> tempLatch == $past(timerCount[15:8]);
   endproperty
   a_rd_lo_latch: assert property (p_rd_lo_latch)
      else $error("count low read did not load latch");

   property p_wr_count;
      @(posedge core_clk) disable iff (!rst_b)
      wrCountLo |=> timerCount == {$past(tempLatch), $past(busWrData)};
   endproperty
   a_wr_count: assert property (p_wr_count)
      else $error("count write lost or wrong");

   property p_latch_keep;
      @(posedge core_clk) disable iff (!rst_b)
      wrAnyHi ##1 ((wrCountLo || wrCaptLo || wrCmpALo || wrCmpBLo)
         && !busRd) [*2] |=> tempLatch == $past(busWrData, 3);
   endproperty
   a_latch_keep: assert property (p_latch_keep)
      else $error("latch not kept across low writes");

   property p_stopped;
      @(posedge core_clk) disable iff (!rst_b)
      clockSel == `TCC_CS_STOP && !wrCountLo |=> $stable(timerCount);
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("count moved while stopped");

   property p_normal_inc;
      @(posedge core_clk) disable iff (!rst_b)
      waveformMode == 4'h0 && clockSel == `TCC_CS_DIV1 && !wrCountLo
         |=> timerCount == $past(timerCount) + 16'h0001;
   endproperty
   a_normal_inc: assert property (p_normal_inc)
      else $error("normal mode did not step by one");

   property p_ovf_wrap;
      @(posedge core_clk) disable iff (!rst_b)
      waveformMode == 4'h0 && timerTick && atMax && !wrCountLo
         |=> timerFlagReg[`TCC_FLAG_OVF] && atBottom;
   endproperty
   a_ovf_wrap: assert property (p_ovf_wrap)
      else $error("overflow not flagged at wrap");

   property p_capture;
      @(posedge core_clk) disable iff (!rst_b)
      capEvent |=> captureValue == $past(timerCount)
         && timerFlagReg[`TCC_FLAG_CAPT];
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture copy and flag not together");

   property p_cap_irq;
      @(posedge core_clk) disable iff (!rst_b)
      timerFlagReg[`TCC_FLAG_CAPT] && timerIrqMaskReg[`TCC_FLAG_CAPT]
         |=> capIrq;
   endproperty
   a_cap_irq: assert property (p_cap_irq)
      else $error("capture interrupt not raised");

   property p_capt_wr_block;
      @(posedge core_clk) disable iff (!rst_b)
      wrCaptLo && !captTop && !capEvent |=> $stable(captureValue);
   endproperty
   a_capt_wr_block: assert property (p_capt_wr_block)
      else $error("capture written outside capture-top mode");

endmodule // tcc_timer16

`default_nettype wire

// >>> design/tcc_defs.svh
// Offsets, field positions, reset values and dividers of the 16-bit timer.
// Included by the timer package users; holds definitions only.
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ==========================================================
// Register indices on the 8-bit processor port
`define TCC_ADDR_COUNT_LO 4'h0
`define TCC_ADDR_COUNT_HI 4'h1
`define TCC_ADDR_CAPT_LO 4'h2
`define TCC_ADDR_CAPT_HI 4'h3
`define TCC_ADDR_CMPA_LO 4'h4
`define TCC_ADDR_CMPA_HI 4'h5
`define TCC_ADDR_CMPB_LO 4'h6
`define TCC_ADDR_CMPB_HI 4'h7
`define TCC_ADDR_CTRL_A 4'h8
`define TCC_ADDR_CTRL_B 4'h9
`define TCC_ADDR_FLAG 4'hA
`define TCC_ADDR_MASK 4'hB

// ==========================================================
// Field positions
`define TCC_CTRLA_WGM_LO 1:0
`define TCC_CTRLB_CS 2:0
`define TCC_CTRLB_WGM_HI 4:3
`define TCC_CTRLB_SRC 5
`define TCC_CTRLB_EDGE 6
`define TCC_FLAG_OVF 0
`define TCC_FLAG_CAPT 5

// ==========================================================
// Reset values, maximum count and fixed tops
`define TCC_RST_BYTE 8'h00
`define TCC_RST_WORD 16'h0000
`define TCC_MAX 16'hFFFF
`define TCC_TOP8 16'h00FF
`define TCC_TOP9 16'h01FF
`define TCC_TOP10 16'h03FF

// ==========================================================
// Clock select codes and prescaler taps
`define TCC_CS_STOP 3'h0
`define TCC_CS_DIV1 3'h1
`define TCC_CS_DIV8 3'h2
`define TCC_CS_DIV64 3'h3
`define TCC_CS_DIV256 3'h4
`define TCC_CS_DIV1024 3'h5
`define TCC_CS_EXT_FALL 3'h6
`define TCC_CS_EXT_RISE 3'h7
`define TCC_PRE_W 10

`endif

// >>> design/tcc_pkg.sv
// Types shared by the 16-bit timer with input capture.
// No surroundings assumed beyond a SystemVerilog compiler.
package tcc_pkg;
   // ==========================================================
   // Count direction, one-hot
   typedef enum logic [1:0] {
      TCC_UP = 2'b01,
      TCC_DOWN = 2'b10
   } tcc_dir_type;
endpackage

// >>> test/tcc_cpu_model.sv
// Processor-side bus model for the 16-bit timer: byte cycles and pairs.
// Assumes a free-running core_clk and a single caller at a time.
`timescale 1ns/1ps
`default_nettype none

module tcc_cpu_model (
   input wire logic core_clk,
   output logic [3:0] busAddr,
   output logic busWr,
   output logic busRd,
   output logic [7:0] busWrData
);
   // ==========================================================
   // Bus idle at time zero
   initial begin
      busAddr = 4'hF;
      busWr = 1'b0;
      busRd = 1'b0;
      busWrData = 8'h00;
   end

   // One byte cycle; strobe stays up so cycles can chain back to back
   task automatic cyc(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
      busAddr <= a;
      busWr <= w;
      busRd <= !w;
      busWrData <= d;
      @(posedge core_clk);
   endtask

   // Release: strobes low, address and data flipped so nothing stale shows
   task automatic rest(input int n);
      busWr <= 1'b0;
      busRd <= 1'b0;
      busAddr <= ~busAddr;
      busWrData <= ~busWrData;
      repeat (n) @(posedge core_clk);
   endtask

   // High then low with nothing between, so no handler can touch the latch
   task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
      cyc(1'b1, lo + 4'h1, v[15:8]);
      cyc(1'b1, lo, v[7:0]);
   endtask
endmodule // tcc_cpu_model

`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the 16-bit timer with capture.
// Assumes the bus model drives the register port; reads checked by queue.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   fails++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module testbench;
   logic core_clk, rst_b, ovfIrqAck, capIrqAck, capturePin;
   logic comparatorOut, extClkPin, busWr, busRd, ovfIrq, capIrq, rdPend;
   logic [3:0] busAddr;
   logic [7:0] busWrData, busRdData, e;
   logic [7:0] expQ[$];
   logic [15:0] v;
   int fails, comparisons, cycles;

   tcc_cpu_model u_tcc_cpu_model (.core_clk(core_clk), .busAddr(busAddr),
      .busWr(busWr), .busRd(busRd), .busWrData(busWrData));
   tcc_timer16 u_tcc_timer16 (.core_clk(core_clk), .rst_b(rst_b),
      .busAddr(busAddr), .busWr(busWr), .busRd(busRd),
      .busWrData(busWrData), .ovfIrqAck(ovfIrqAck), .capIrqAck(capIrqAck),
      .capturePin(capturePin), .comparatorOut(comparatorOut),
      .extClkPin(extClkPin), .busRdData(busRdData), .ovfIrq(ovfIrq),
      .capIrq(capIrq));

   // ==========================================================
   // Bus helpers; a read notes its expected byte first
   task automatic rd(input logic [3:0] a, input logic [7:0] x);
      expQ.push_back(x);
      u_tcc_cpu_model.cyc(1'b0, a, 8'h00);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      u_tcc_cpu_model.cyc(1'b1, a, d);
   endtask
   task automatic rd16(input logic [3:0] lo, input logic [15:0] x);
      rd(lo, x[7:0]);
      rd(lo + 4'h1, x[15:8]);
   endtask
   task automatic idle(input int n);
      u_tcc_cpu_model.rest(n);
   endtask
   // Irq lines sampled mid-cycle, where they have settled
   task automatic irqs(input logic o, input logic c);
      @(negedge core_clk);
      `CHK("ovfIrq", o, ovfIrq)
      `CHK("capIrq", c, capIrq)
      @(posedge core_clk);
   endtask
   task automatic final_report();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Read data shows one cycle after the read edge; oldest note wins
   always @(posedge core_clk) rdPend <= busRd & rst_b;
   always @(negedge core_clk) begin
      if (rdPend === 1'b1) begin
         e = expQ.pop_front();
         `CHK("busRdData", e, busRdData)
      end
   end

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         final_report();
      end
   end

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // ==========================================================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      {ovfIrqAck, capIrqAck, comparatorOut, extClkPin} = 4'h0;
      capturePin = 1'b1;
      fails = 0;
      comparisons = 0;
      cycles = 0;
      void'($urandom(62));
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      // All registers clear, unmapped index 12 reads zero
      for (int i = 0; i < 13; i++) rd(4'(i), 8'h00);
      // Random pairs through the latch while stopped
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom());
         u_tcc_cpu_model.wr16(4'h0, v);
         rd16(4'h0, v);
      end
      // One high write serves several low writes
      wr(4'h1, 8'hAB);
      wr(4'h0, 8'h12);
      wr(4'h4, 8'h34);
      wr(4'h6, 8'h56);
      rd16(4'h0, 16'hAB12);
      rd16(4'h4, 16'hAB34);
      rd16(4'h6, 16'hAB56);
      u_tcc_cpu_model.wr16(4'h2, 16'h7788);
      rd16(4'h2, 16'h0000);
      // Count every clock; write wins over the tick, carry reaches latch
      wr(4'h9, 8'h01);
      u_tcc_cpu_model.wr16(4'h0, 16'h12FF);
      rd(4'h0, 8'hFF);
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h13);
      // Normal mode wraps from MAX to zero and flags overflow
      u_tcc_cpu_model.wr16(4'h0, 16'hFFFE);
      rd(4'h0, 8'hFE);
      rd(4'h0, 8'hFF);
      rd(4'hA, 8'h01);
      wr(4'hA, 8'h01);
      rd(4'hA, 8'h00);
      // Single slope with top 0xFF: clears after top, flags overflow
      wr(4'h8, 8'h01);
      wr(4'h9, 8'h09);
      u_tcc_cpu_model.wr16(4'h0, 16'h00FF);
      rd(4'h0, 8'hFF);
      rd(4'h0, 8'h00);
      rd(4'hA, 8'h01);
      wr(4'hB, 8'h01);
      idle(2);
      irqs(1'b1, 1'b0);
      ovfIrqAck <= 1'b1;
      @(posedge core_clk);
      ovfIrqAck <= 1'b0;
      repeat (2) @(posedge core_clk);
      irqs(1'b0, 1'b0);
      // Dual slope top 0xFF turns down after top
      wr(4'h9, 8'h01);
      u_tcc_cpu_model.wr16(4'h0, 16'h00FE);
      rd(4'h0, 8'hFE);
      rd(4'h0, 8'hFF);
      rd(4'h0, 8'hFE);
      // Reaching bottom while falling turns up and flags overflow
      u_tcc_cpu_model.wr16(4'h0, 16'h0001);
      rd(4'h0, 8'h01);
      rd(4'h0, 8'h00);
      rd(4'hA, 8'h01);
      // Stopped normal mode; falling pin edge captures the count
      wr(4'h8, 8'h00);
      wr(4'h9, 8'h00);
      wr(4'hA, 8'hFF);
      wr(4'hB, 8'h20);
      u_tcc_cpu_model.wr16(4'h0, 16'h1234);
      idle(1);
      capturePin <= 1'b0;
      idle(2);
      rd16(4'h2, 16'h1234);
      rd(4'hA, 8'h20);
      idle(1);
      irqs(1'b0, 1'b1);
      capIrqAck <= 1'b1;
      @(posedge core_clk);
      capIrqAck <= 1'b0;
      rd(4'hA, 8'h00);
      // Rising edge selected: rise captures, fall does not
      wr(4'h9, 8'h40);
      u_tcc_cpu_model.wr16(4'h0, 16'h5678);
      idle(1);
      capturePin <= 1'b1;
      idle(2);
      rd16(4'h2, 16'h5678);
      u_tcc_cpu_model.wr16(4'h0, 16'h9ABC);
      idle(1);
      capturePin <= 1'b0;
      idle(2);
      rd16(4'h2, 16'h5678);
      // Comparator as source, then write-one clears the flag
      wr(4'h9, 8'h60);
      idle(1);
      comparatorOut <= 1'b1;
      idle(2);
      rd16(4'h2, 16'h9ABC);
      wr(4'hA, 8'h20);
      rd(4'hA, 8'h00);
      // Capture-top mode: capture writable, pin edges ignored
      wr(4'h9, 8'h10);
      u_tcc_cpu_model.wr16(4'h2, 16'h4321);
      idle(1);
      capturePin <= 1'b1;
      idle(2);
      capturePin <= 1'b0;
      idle(2);
      rd16(4'h2, 16'h4321);
      // External falling, then rising, edges as the tick
      for (int s = 6; s < 8; s++) begin
         wr(4'h9, 8'(s));
         u_tcc_cpu_model.wr16(4'h0, 16'h0000);
         idle(1);
         for (int i = 0; i < 5; i++) begin
            extClkPin <= 1'b1;
            repeat (3) @(posedge core_clk);
            extClkPin <= 1'b0;
            repeat (3) @(posedge core_clk);
         end
         rd(4'h0, 8'h05);
      end
      rd(4'h9, 8'h07);
      // Divide by eight: any 64 clocks hold exactly eight ticks
      wr(4'h9, 8'h02);
      u_tcc_cpu_model.wr16(4'h0, 16'h00F8);
      idle(64);
      rd16(4'h0, 16'h0100);
      // Clear at compare A top; no overflow short of MAX
      u_tcc_cpu_model.wr16(4'h4, 16'h0005);
      wr(4'h9, 8'h09);
      u_tcc_cpu_model.wr16(4'h0, 16'h0004);
      rd(4'h0, 8'h04);
      rd(4'h0, 8'h05);
      rd(4'h0, 8'h00);
      rd(4'hA, 8'h00);
      idle(2);
      final_report();
   end
endmodule // testbench

`default_nettype wire
